// *** iole_pkg.sv ***
// Constants for the increment / or-literal / load-literal execute unit.
// Assumes a 14-bit instruction word and an 8-bit data path.
// Function
// [RULE_01] Opcode 00 1010 adds one to the addressed file register, updates null flag.
// [RULE_02] Destination bit clear writes the accumulator; set writes the file register back.
// [RULE_03] Increment-and-skip keeps flags; a null result discards the next instruction.
// [RULE_04] Opcode 11 1000 ORs the literal into the accumulator, updates null flag.
// [RULE_05] Opcode 11 00xx loads the literal into the accumulator, flags unchanged.
// [RULE_06] The two unused load-literal bits are ignored by the decoder.
// [RULE_07] Null flag is set for a zero result, cleared otherwise; 0xFF wraps.
package iole_pkg;

    // Word layout
    localparam int INSTR_W   = 14;
    localparam int DATA_W    = 8;
    localparam int FADDR_W   = 7;
    localparam int DEST_BIT  = 7;
    localparam int FADDR_LSB = 0;
    localparam int LIT_LSB   = 0;

    // Opcode fields: six bits for file and or-literal forms, four for load-literal
    localparam logic [5:0] OP_INCREMENT_FILE       = 6'h0A;
    localparam logic [5:0] OP_INCREMENT_FILE_SKIP  = 6'h0F;
    localparam logic [5:0] OP_OR_LITERAL_ACC       = 6'h38;
    localparam logic [3:0] OP_LOAD_LITERAL_ACC     = 4'hC;

    // Reset values
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic       NULL_RESET = 1'b0;

    // Execution cycles
    localparam int CYCLES_PLAIN = 1;
    localparam int CYCLES_SKIP  = 2;

    // Sequencer states
    typedef enum logic {
        IOLE_ST_RUN,
        IOLE_ST_FLUSH
    } iole_state_e;

endpackage

// *** iole_exec.sv ***
// Decode and execute of four instructions: increment file, increment file
// with skip on null, OR literal into accumulator, load literal.
// A null result of the skip form voids the next word taken; unknown
// words raise unknown_pulse and change no state.
// Assumes fetch and file storage run on clk; file read data is a
// combinational read of file_rd_addr, and writes land on the clock edge.
// Fetch never stalls: every valid word is taken on the edge it stands.
`timescale 1ns/1ps

module iole_exec #(
    parameter int INSTR_W = iole_pkg::INSTR_W,
    parameter int DATA_W  = iole_pkg::DATA_W,
    parameter int FADDR_W = iole_pkg::FADDR_W
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Instruction from fetch stage
    input  wire logic               instr_valid,
    input  wire logic [INSTR_W-1:0] instr_word,
    output logic                    instr_ready,
    // File register read port
    output logic [FADDR_W-1:0]      file_rd_addr,
    input  wire logic [DATA_W-1:0]  file_rd_data,
    // File register write port
    output logic                    file_wr_en,
    output logic [FADDR_W-1:0]      file_wr_addr,
    output logic [DATA_W-1:0]       file_wr_data,
    // Architectural state
    output logic [DATA_W-1:0]       acc_value,
    output logic                    null_flag,
    // Execution status
    output logic                    retire_pulse,
    output logic                    skip_pulse,
    output logic                    discard_pulse,
    output logic                    unknown_pulse
);

    // Sequencer and state registers
    iole_pkg::iole_state_e state_r;
    iole_pkg::iole_state_e state_nxt;
    logic [DATA_W-1:0]     acc_r;
    logic [DATA_W-1:0]     acc_nxt;
    logic                  null_r;
    logic                  null_nxt;
    logic                  wr_en_r;
    logic [FADDR_W-1:0]    wr_addr_r;
    logic [DATA_W-1:0]     wr_data_r;
    logic                  retire_r;
    logic                  skip_r;
    logic                  discard_r;
    logic                  unknown_r;

    // Decoded fields
    logic [5:0]            op6;
    logic [3:0]            op4;
    logic                  dest_file;
    logic [FADDR_W-1:0]    faddr;
    logic [DATA_W-1:0]     literal;
    logic                  is_inc;
    logic                  is_incsz;
    logic                  is_orl;
    logic                  is_ldl;
    logic                  is_known;

    // Handshake and sequencing
    logic                  take;
    logic                  exec;
    logic                  flush;

    // Operand and results
    logic                  fwd_hit;
    logic [DATA_W-1:0]     file_val;
    logic [DATA_W-1:0]     inc_res;
    logic [DATA_W-1:0]     or_res;
    logic                  inc_any;
    logic                  inc_null;
    logic                  or_null;

    // Skip and routing
    logic                  do_skip;
    logic                  wr_acc;
    logic                  wr_file;

    // True when an 8-bit result is all zero
    function automatic logic is_null(input logic [7:0] v);
        return (v == 8'h00); // [RULE_07]
    endfunction

    // Field extraction
    assign op6       = instr_word[INSTR_W-1 -: 6];
    assign op4       = instr_word[INSTR_W-1 -: 4];
    assign dest_file = instr_word[iole_pkg::DEST_BIT];
    assign faddr     = instr_word[iole_pkg::FADDR_LSB +: FADDR_W];
    assign literal   = instr_word[iole_pkg::LIT_LSB +: DATA_W];

    // Opcode decode; load-literal compares only the top four bits
    assign is_inc   = (op6 == iole_pkg::OP_INCREMENT_FILE);       // [RULE_01]
    assign is_incsz = (op6 == iole_pkg::OP_INCREMENT_FILE_SKIP);  // [RULE_03]
    assign is_orl   = (op6 == iole_pkg::OP_OR_LITERAL_ACC);       // [RULE_04]
    assign is_ldl   = (op4 == iole_pkg::OP_LOAD_LITERAL_ACC);     // [RULE_05] [RULE_06]

    // Handshake; word taken in flush state is dropped as a no-operation
    assign instr_ready = 1'b1;
    assign take        = instr_valid;
    assign flush       = take && (state_r == iole_pkg::IOLE_ST_FLUSH);
    assign exec        = take && (state_r == iole_pkg::IOLE_ST_RUN);

    // Operand read with forwarding of the write still in flight
    assign file_rd_addr = faddr;
    assign fwd_hit      = wr_en_r && (wr_addr_r == faddr);
    assign file_val     = fwd_hit ? wr_data_r : file_rd_data;

    // Arithmetic; increment wraps 0xFF to 0x00
    assign inc_res  = file_val + 8'h01;                           // [RULE_01] [RULE_07]
    assign or_res   = acc_r | literal;                            // [RULE_04]
    assign inc_any  = is_inc || is_incsz;
    assign inc_null = is_null(inc_res);
    assign or_null  = is_null(or_res);                            // [RULE_07]
    assign do_skip  = exec && is_incsz && inc_null;               // [RULE_03]

    // Any of the four instructions; other words only raise a pulse
    assign is_known = inc_any || is_orl || is_ldl;

    // Destination routing by the destination bit
    assign wr_acc  = exec && ((inc_any && !dest_file) || is_orl || is_ldl); // [RULE_02]
    assign wr_file = exec && inc_any && dest_file;                          // [RULE_02]

    // Next accumulator value
    always_comb begin
        acc_nxt = acc_r;
        if (wr_acc) begin
            if (inc_any) begin
                acc_nxt = inc_res;                                // [RULE_02]
            end else if (is_orl) begin
                acc_nxt = or_res;                                 // [RULE_04]
            end else begin
                acc_nxt = literal;                                // [RULE_05]
            end
        end
    end

    // Null flag: plain increment and OR update it, skip and load do not
    always_comb begin
        null_nxt = null_r;
        if (exec && is_inc) begin
            null_nxt = inc_null;                                  // [RULE_01] [RULE_07]
        end else if (exec && is_orl) begin
            null_nxt = or_null;                                   // [RULE_04] [RULE_07]
        end
    end

    // Skip sequencer: a null skip result turns the next word into a no-operation
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            iole_pkg::IOLE_ST_RUN: begin
                if (do_skip) begin
                    state_nxt = iole_pkg::IOLE_ST_FLUSH;          // [RULE_03]
                end
            end
            iole_pkg::IOLE_ST_FLUSH: begin
                if (flush) begin
                    state_nxt = iole_pkg::IOLE_ST_RUN;            // [RULE_03]
                end
            end
        endcase
    end

    // Sequencer and architectural state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= iole_pkg::IOLE_ST_RUN;
            acc_r   <= iole_pkg::ACC_RESET;
            null_r  <= iole_pkg::NULL_RESET;
        end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            null_r  <= null_nxt;
        end
    end

    // File write-back, one cycle after the instruction is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en_r   <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            wr_en_r <= wr_file;                                   // [RULE_02]
            if (wr_file) begin
                wr_addr_r <= faddr;
                wr_data_r <= inc_res;                             // [RULE_01]
            end
        end
    end

    // Status pulses, one cycle each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            retire_r  <= 1'b0;
            skip_r    <= 1'b0;
            discard_r <= 1'b0;
            unknown_r <= 1'b0;
        end else begin
            retire_r  <= exec && is_known;
            skip_r    <= do_skip;
            discard_r <= flush;                                   // [RULE_03]
            unknown_r <= exec && !is_known;
        end
    end

    // File write port
    assign file_wr_en    = wr_en_r;
    assign file_wr_addr  = wr_addr_r;
    assign file_wr_data  = wr_data_r;

    // Architectural state and status pulses
    assign acc_value     = acc_r;
    assign null_flag     = null_r;
    assign retire_pulse  = retire_r;
    assign skip_pulse    = skip_r;
    assign discard_pulse = discard_r;
    assign unknown_pulse = unknown_r;

endmodule

// *** iole_file_mdl.sv ***
// File register storage facing the execute unit.
// Assumes writes land on the edge and reads are combinational.
`timescale 1ns/1ps
module iole_file_mdl (
    // Clock
    input  wire logic       clk,
    // Read port
    input  wire logic [6:0] rd_addr,
    output logic      [7:0] rd_data,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data
);
    logic [7:0] mem [128];
    // Every cell starts one below the wrap point
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'hFE;
    end
    // Same-cycle read
    assign rd_data = mem[rd_addr];
    // Write on the edge
    always @(posedge clk) begin
        if (wr_en) mem[wr_addr] <= wr_data;
    end
endmodule

// *** iole_chk.sv ***
// Port assertions for the execute unit.
// Assumes one clock domain; bound onto iole_exec.
`timescale 1ns/1ps
module iole_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Instruction
    input wire logic        instr_valid,
    input wire logic [13:0] instr_word,
    // File ports
    input wire logic [6:0]  file_rd_addr,
    input wire logic        file_wr_en,
    input wire logic [6:0]  file_wr_addr,
    input wire logic [7:0]  file_wr_data,
    // State and status
    input wire logic [7:0]  acc_value,
    input wire logic        null_flag,
    input wire logic        retire_pulse,
    input wire logic        skip_pulse,
    input wire logic        discard_pulse,
    input wire logic        unknown_pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic flush_r;
    // Decode helpers
    wire [5:0] op   = instr_word[13:8];
    wire [7:0] lit  = instr_word[7:0];
    wire       dst  = instr_word[7];
    wire       live = instr_valid && !skip_pulse && !flush_r;
    wire       inc  = live && op == iole_pkg::OP_INCREMENT_FILE;
    wire       fop  = inc || (live && op == iole_pkg::OP_INCREMENT_FILE_SKIP);
    wire       ld   = live && op[5:2] == iole_pkg::OP_LOAD_LITERAL_ACC;
    wire [7:0] res  = file_wr_en ? file_wr_data : acc_value;
    // Flush pending until a valid word is consumed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) flush_r <= 1'b0;
        else flush_r <= (skip_pulse || flush_r) && !instr_valid;
    end
    sequence s_skip_in;
        fop && !inc;
    endsequence
    sequence s_void;
        discard_pulse && !retire_pulse && !file_wr_en && $stable(acc_value);
    endsequence
    property p_inc;
        inc |=> retire_pulse && null_flag == (res == 8'h00);
    endproperty
    a_inc: assert property (p_inc) else $error("increment flag wrong");
    property p_one;
        inc |=> !skip_pulse ##1 !discard_pulse;
    endproperty
    a_one: assert property (p_one) else $error("increment not single");
    property p_dest;
        fop |=> file_wr_en == $past(dst) && (!file_wr_en || file_wr_addr == $past(file_rd_addr));
    endproperty
    a_dest: assert property (p_dest) else $error("destination wrong");
    property p_skflag;
        s_skip_in |=> null_flag == $past(null_flag) && skip_pulse == (res == 8'h00);
    endproperty
    a_skflag: assert property (p_skflag) else $error("skip flag wrong");
    property p_flush;
        s_skip_in ##1 (skip_pulse && instr_valid) |=> s_void;
    endproperty
    a_flush: assert property (p_flush) else $error("word not discarded");
    property p_or;
        live && op == iole_pkg::OP_OR_LITERAL_ACC
            |=> acc_value == ($past(acc_value) | $past(lit)) && null_flag == (acc_value == 8'h00);
    endproperty
    a_or: assert property (p_or) else $error("or literal wrong");
    property p_load;
        ld |=> acc_value == $past(lit) && $stable(null_flag);
    endproperty
    a_load: assert property (p_load) else $error("load literal wrong");
    property p_loadx;
        ld && op[1:0] != 2'h0 |=> retire_pulse && !unknown_pulse;
    endproperty
    a_loadx: assert property (p_loadx) else $error("load not decoded");
endmodule
bind iole_exec iole_chk u_iole_chk (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_rd_addr(file_rd_addr), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .acc_value(acc_value),
    .null_flag(null_flag), .retire_pulse(retire_pulse), .skip_pulse(skip_pulse),
    .discard_pulse(discard_pulse), .unknown_pulse(unknown_pulse));

// *** tb_top.sv ***
// Self-checking bench for the execute unit.
// Assumes the file model starts every cell at 8'hFE.
`timescale 1ns/1ps
module tb_top;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        iv    = 1'b0;
    logic [13:0] iw    = 14'h0000;
    logic [13:0] rw;
    logic        rdy, wen, nf, rp, sp, dp, up;
    logic [6:0]  ra, wa, m_wa;
    logic [7:0]  rd, wd, acc, m_wd;
    logic [7:0]  m_mem [128];
    logic [7:0]  m_acc = 8'h00;
    logic        m_nf = 1'b0;
    logic        m_disc = 1'b0;
    logic [4:0]  m_p = 5'h00;
    logic [31:0] seed = 32'hA54F6152;
    logic [5:0]  op_tab [4] = '{6'h0A, 6'h0F, 6'h38, 6'h30};
    logic [13:0] corner [13] = '{14'h0F85, 14'h0F85, 14'h0A85, 14'h0A86, 14'h0A86,
        14'h0A06, 14'h3300, 14'h3800, 14'h3835, 14'h305A, 14'h335A, 14'h0000, 14'h3FFF};
    int          num_errors = 0;
    int          n_tests = 0;
    iole_exec u_iole_exec (.clk(clk), .rst_n(rst_n), .instr_valid(iv), .instr_word(iw),
        .instr_ready(rdy), .file_rd_addr(ra), .file_rd_data(rd), .file_wr_en(wen),
        .file_wr_addr(wa), .file_wr_data(wd), .acc_value(acc), .null_flag(nf),
        .retire_pulse(rp), .skip_pulse(sp), .discard_pulse(dp), .unknown_pulse(up));
    iole_file_mdl u_iole_file_mdl (.clk(clk), .rd_addr(ra), .rd_data(rd), .wr_en(wen),
        .wr_addr(wa), .wr_data(wd));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic complete_run();
        $display("errors=%0d tests=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Reference: order retire, skip, discard, unknown, write
    task automatic exec(input logic [13:0] w);
        logic [7:0] r;
        r = m_mem[w[6:0]] + 8'h01;
        m_p = 5'h00;
        m_wa = w[6:0];
        m_wd = r;
        if (m_disc) begin
            m_p[2] = 1'b1;
            m_disc = 1'b0;
        end else if (w[13:8] == 6'h0A || w[13:8] == 6'h0F) begin
            m_p = {1'b1, 3'h0, w[7]};
            if (w[7]) m_mem[w[6:0]] = r;
            else m_acc = r;
            if (w[11:8] == 4'hA) m_nf = (r == 8'h00);
            else m_p[3] = (r == 8'h00);
            m_disc = m_p[3];
        end else if (w[13:8] == 6'h38) begin
            m_p[4] = 1'b1;
            m_acc = m_acc | w[7:0];
            m_nf = (m_acc == 8'h00);
        end else if (w[13:10] == 4'hC) begin
            m_p[4] = 1'b1;
            m_acc = w[7:0];
        end else m_p[1] = 1'b1;
    endtask
    task automatic step(input logic [13:0] w);
        @(posedge clk);
        if (iv) exec(iw);
        iv <= 1'b1;
        iw <= w;
        #1;
        chk(acc, m_acc);
        chk({7'h00, nf}, {7'h00, m_nf});
        chk({3'h0, rp, sp, dp, up, wen}, {3'h0, m_p});
        if (m_p[0]) chk(wd, m_wd);
        if (m_p[0]) chk({1'b0, wa}, {1'b0, m_wa});
        chk({7'h00, rdy}, 8'h01);
        chk({1'b0, ra}, {1'b0, w[6:0]});
    endtask
    // Watchdog
    initial begin
        #20000;
        num_errors++;
        $display("MISMATCH t=%0t watchdog", $time);
        complete_run();
    end
    // Corner words, then random traffic
    initial begin
        for (int i = 0; i < 128; i++) m_mem[i] = 8'hFE;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (corner[i]) step(corner[i]);
        // Reset in mid-run with a discard pending: it must not survive
        step(14'h0F81);
        step(14'h0F01);
        @(posedge clk);
        exec(iw);
        iv    <= 1'b0;
        rst_n <= 1'b0;
        m_acc  = 8'h00;
        m_nf   = 1'b0;
        m_disc = 1'b0;
        m_p    = 5'h00;
        #1;
        chk(acc, 8'h00);
        chk({3'h0, rp, sp, dp, up, wen}, 8'h00);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        step(14'h0A81);
        repeat (400) begin
            seed = xs(seed);
            rw = {op_tab[seed[9:8]], seed[7:0]};
            if (!seed[9]) rw[6:2] = 5'h00;
            if (seed[9:8] == 2'h3) rw[9:8] = seed[11:10];
            if (seed[20:18] == 3'h0) rw = seed[31:18];
            step(rw);
        end
        step(14'h3FFF);
        complete_run();
    end
endmodule
